// >>> design/lsd_pkg.sv
// package for the segment lcd drive controller: field positions, codes, levels
// assumes one 125 MHz clock domain and synchronous active-low reset
package lsd_pkg;

  // ****************************************************************
  // mode register fields, plus the output enable bit of the segment enable register
  // ****************************************************************
  localparam int DUTY_LO    = 0;
  localparam int DUTY_HI    = 1;
  localparam int BIAS_BIT   = 2;
  localparam int MULT_BIT   = 4;
  localparam int DIV_LO     = 5;
  localparam int DIV_HI     = 6;
  localparam int SRC_BIT    = 7;
  localparam int OUTEN_BIT  = 6;

  localparam logic [7:0] MODE_RST  = 8'h00;
  localparam logic [7:0] SEGEN_RST = 8'h00;

  // ****************************************************************
  // geometry
  // ****************************************************************
  localparam int NUM_COM     = 4;
  localparam int NUM_SEG     = 40;
  localparam int RAM_BYTES   = 20;
  localparam logic [7:0] RAM_BASE = 8'h40;
  localparam logic [7:0] RAM_LAST = 8'h53;
  localparam int SEG_OUT_LO  = 18;
  localparam int SEG_IO_LO   = 26;
  localparam int SEG_PULL_LO = 34;

  // duty codes
  localparam logic [1:0] DUTY_RSV = 2'h0;
  localparam logic [1:0] DUTY_2   = 2'h1;
  localparam logic [1:0] DUTY_3   = 2'h2;
  localparam logic [1:0] DUTY_4   = 2'h3;

  // drive levels; vHigh is also the supply level used at reset
  typedef enum logic [2:0] {
    LV_GND  = 3'h0,
    LV_LOW  = 3'h1,
    LV_MID  = 3'h2,
    LV_HIGH = 3'h3,
    LV_OPEN = 3'h4
  } lsd_level_t;

  // divider ratios selected by mode bits 6:5 (prescale counts)
  localparam logic [7:0] DIV_R0 = 8'h01;
  localparam logic [7:0] DIV_R1 = 8'h02;
  localparam logic [7:0] DIV_R2 = 8'h04;
  localparam logic [7:0] DIV_R3 = 8'h08;

  typedef struct packed {
    logic [1:0] duty;
    logic       thirdBias;
    logic       multEn;
    logic [1:0] divSel;
    logic       srcSel;
  } lsd_mode_t;

endpackage

// >>> design/lsd_drive.sv
// segment lcd drive controller: commons, segments, supply control
// assumes two count-source tick inputs sync to clk and a byte write port to ram
`timescale 1ns/1ps
module lsd_drive
  import lsd_pkg::*;
(
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  // register writes
  input  wire logic                  modeWr,
  input  wire logic [7:0]            modeData,
  input  wire logic                  segEnWr,
  input  wire logic [7:0]            segEnData,
  input  wire logic                  ramWr,
  input  wire logic [7:0]            ramAddr,
  input  wire logic [7:0]            ramData,
  // count sources (one-cycle ticks)
  input  wire logic                  srcTickA,
  input  wire logic                  srcTickB,
  // status and supply control
  output logic [7:0]                 modeOut,
  output logic [7:0]                 segEnOut,
  output logic                       multiplierOn,
  output logic                       highTiedToSupply,
  output logic                       lcd_drive_clock,
  output logic [1:0]                 activeCommon,
  // pins
  output lsd_level_t                 commonLevel [NUM_COM],
  output lsd_level_t                 segLevel [NUM_SEG],
  output logic [NUM_SEG-1:0]         segPullUp
);

  // ****************************************************************
  // decode helpers
  // ****************************************************************
  function automatic logic [2:0] lastCom(input logic [1:0] d);
    case (d)
      DUTY_2:  lastCom = 3'h1;
      DUTY_3:  lastCom = 3'h2;
      DUTY_4:  lastCom = 3'h3;
      default: lastCom = 3'h0;
    endcase
  endfunction

  function automatic logic [7:0] divRatio(input logic [1:0] s);
    case (s)
      2'h0:    divRatio = DIV_R0;
      2'h1:    divRatio = DIV_R1;
      2'h2:    divRatio = DIV_R2;
      default: divRatio = DIV_R3;
    endcase
  endfunction

  // ****************************************************************
  // registers and display ram
  // ****************************************************************
  logic [7:0] modeReg, modeNext, segEnReg, segEnNext;
  logic [7:0] ramReg [RAM_BYTES];
  logic [7:0] ramNext [RAM_BYTES];
  lsd_mode_t  m;
  logic       multReg, multNext, tieReg, tieNext;

  always_comb begin
    modeNext  = modeWr ? modeData : modeReg;
    segEnNext = segEnWr ? segEnData : segEnReg;
    // multiplier needs the output enable: a wrong software order cannot start it
    multNext  = modeNext[MULT_BIT] & segEnNext[OUTEN_BIT];
    tieNext   = ~segEnNext[OUTEN_BIT];
    for (int i = 0; i < RAM_BYTES; i++) begin
      ramNext[i] = ramReg[i];
    end
    // window 0x40..0x53, others ignored
    if (ramWr && ramAddr >= RAM_BASE && ramAddr <= RAM_LAST) begin
      ramNext[5'(ramAddr - RAM_BASE)] = ramData;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      modeReg  <= MODE_RST;
      segEnReg <= SEGEN_RST;
      multReg  <= MODE_RST[MULT_BIT] & SEGEN_RST[OUTEN_BIT];
      tieReg   <= ~SEGEN_RST[OUTEN_BIT];
    end else begin
      modeReg  <= modeNext;
      segEnReg <= segEnNext;
      multReg  <= multNext;
      tieReg   <= tieNext;
    end
    ramReg <= ramNext;
  end

  assign m = '{duty: modeReg[DUTY_HI:DUTY_LO], thirdBias: modeReg[BIAS_BIT],
               multEn: modeReg[MULT_BIT], divSel: modeReg[DIV_HI:DIV_LO],
               srcSel: modeReg[SRC_BIT]};

  wire logic outEn = segEnReg[OUTEN_BIT];

  // ****************************************************************
  // drive clock and common scan
  // ****************************************************************
  typedef enum logic [1:0] { ST_IDLE = 2'b01, ST_SCAN = 2'b10 } lsd_state_t;
  lsd_state_t stReg, stNext;
  logic [7:0] divReg, divNext;
  logic [1:0] comReg, comNext;
  logic       tickReg, tickNext, phaseReg, phaseNext;

  always_comb begin
    logic srcTick;
    logic scan;
    srcTick  = m.srcSel ? srcTickB : srcTickA;
    scan     = 1'b0;
    stNext   = stReg;
    divNext  = divReg;
    comNext  = comReg;
    tickNext = 1'b0;
    phaseNext = phaseReg;
    case (stReg)
      ST_IDLE: begin
        divNext = 8'h00;
        comNext = 2'h0;
        if (outEn && m.duty != DUTY_RSV) begin
          stNext = ST_SCAN;
        end
      end
      ST_SCAN: begin
        scan = 1'b1;
        if (!outEn || m.duty == DUTY_RSV) begin
          stNext = ST_IDLE;
        end
      end
      default: stNext = ST_IDLE;
    endcase
    if (scan && srcTick) begin
      if (divReg + 8'h01 >= divRatio(m.divSel)) begin
        divNext  = 8'h00;
        tickNext = 1'b1;
        // step commons, wrap after last active
        if ({1'b0, comReg} >= lastCom(m.duty)) begin
          comNext   = 2'h0;
          phaseNext = ~phaseReg;
        end else begin
          comNext = comReg + 2'h1;
        end
      end else begin
        divNext = divReg + 8'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      stReg    <= ST_IDLE;
      divReg   <= 8'h00;
      comReg   <= 2'h0;
      tickReg  <= 1'b0;
      phaseReg <= 1'b0;
    end else begin
      stReg    <= stNext;
      divReg   <= divNext;
      comReg   <= comNext;
      tickReg  <= tickNext;
      phaseReg <= phaseNext;
    end
  end

  // ****************************************************************
  // pin levels
  // ****************************************************************
  lsd_level_t comNextLv [NUM_COM];
  lsd_level_t segNextLv [NUM_SEG];
  lsd_level_t comLvReg [NUM_COM];
  lsd_level_t segLvReg [NUM_SEG];
  // pull-ups only on the upper io-shared lines while idle
  localparam logic [NUM_SEG-1:0] PULL_IDLE =
    {{(NUM_SEG-SEG_PULL_LO){1'h1}}, {SEG_PULL_LO{1'h0}}};
  logic [NUM_SEG-1:0] pullNext, pullReg;
  wire logic running = (stReg == ST_SCAN);
  // half bias: mid and low are the same supply, only mid is used
  wire lsd_level_t selHi  = phaseReg ? LV_GND : LV_HIGH;
  wire lsd_level_t selLo  = phaseReg ? LV_HIGH : LV_GND;
  wire lsd_level_t nselC  = m.thirdBias ? (phaseReg ? LV_MID : LV_LOW) : LV_MID;
  wire lsd_level_t nselS  = m.thirdBias ? (phaseReg ? LV_LOW : LV_MID) : LV_MID;

  genvar g;
  generate
    for (g = 0; g < NUM_COM; g++) begin : gCom
      always_comb begin
        if (!running) begin
          comNextLv[g] = LV_HIGH;
        end else if (g > lastCom(m.duty)) begin
          comNextLv[g] = LV_OPEN;
        end else begin
          comNextLv[g] = (comReg == 2'(g)) ? selHi : nselC;
        end
      end
    end
    for (g = 0; g < NUM_SEG; g++) begin : gSeg
      always_comb begin
        logic on;
        on = ramReg[g/2][(g%2)*4 + int'(comReg)];
        pullNext[g] = (g >= SEG_PULL_LO) && !running;
        if (running) begin
          segNextLv[g] = on ? selLo : nselS;
        end else if (g < SEG_OUT_LO) begin
          segNextLv[g] = LV_HIGH;
        end else begin
          segNextLv[g] = LV_OPEN;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_COM; i++) begin
        comLvReg[i] <= LV_HIGH;
      end
      for (int i = 0; i < NUM_SEG; i++) begin
        segLvReg[i] <= (i < SEG_OUT_LO) ? LV_HIGH : LV_OPEN;
      end
      pullReg <= PULL_IDLE;
    end else begin
      comLvReg <= comNextLv;
      segLvReg <= segNextLv;
      pullReg  <= pullNext;
    end
  end

  assign commonLevel      = comLvReg;
  assign segLevel         = segLvReg;
  assign segPullUp        = pullReg;
  assign modeOut          = modeReg;
  assign segEnOut         = segEnReg;
  // multiplier only runs once outputs are enabled, guarding a bad order
  assign multiplierOn     = multReg;
  assign highTiedToSupply = tieReg;
  assign lcd_drive_clock  = tickReg;
  assign activeCommon     = comReg;

  // ****************************************************************
  // checks
  // ****************************************************************
  unused_com_a: assert property (@(posedge clk) disable iff (!reset_n)
    running && m.duty == DUTY_2 && $stable(modeReg) |=> comLvReg[3] == LV_OPEN)
    else $error("unused common driven");
  reserved_duty_a: assert property (@(posedge clk) disable iff (!reset_n)
    (m.duty == DUTY_RSV) [*2] |=> comLvReg[0] == LV_HIGH)
    else $error("reserved duty not idle");
  supply_tie_a: assert property (@(posedge clk) disable iff (!reset_n)
    !segEnReg[OUTEN_BIT] |-> highTiedToSupply)
    else $error("high level not tied");
  com_wrap_a: assert property (@(posedge clk) disable iff (!reset_n)
    tickReg |-> {1'b0, comReg} <= lastCom(m.duty) || $changed(modeReg))
    else $error("common beyond last");
  mult_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
    multiplierOn |-> segEnReg[OUTEN_BIT] && modeReg[MULT_BIT])
    else $error("multiplier without output enable");
  scan_stop_a: assert property (@(posedge clk) disable iff (!reset_n)
    !outEn |=> !running)
    else $error("scan kept running without enable");
  // pin levels are registered, so they follow the deciding state one cycle later
  pull_idle_a: assert property (@(posedge clk) disable iff (!reset_n)
    !running |=> pullReg == PULL_IDLE)
    else $error("idle pull-ups wrong");
  seg_idle_a: assert property (@(posedge clk) disable iff (!reset_n)
    !running |=> segLvReg[0] == LV_HIGH && segLvReg[SEG_OUT_LO] == LV_OPEN)
    else $error("idle segment levels wrong");
  duty_three_a: assert property (@(posedge clk) disable iff (!reset_n)
    running && m.duty == DUTY_3 |=> comLvReg[2] != LV_OPEN && comLvReg[3] == LV_OPEN)
    else $error("duty three commons wrong");
  duty_four_a: assert property (@(posedge clk) disable iff (!reset_n)
    running && m.duty == DUTY_4 |=> comLvReg[3] != LV_OPEN)
    else $error("duty four common open");
  // half bias shares one level for both middle supplies
  half_bias_a: assert property (@(posedge clk) disable iff (!reset_n)
    running && !m.thirdBias |=> comLvReg[0] != LV_LOW && segLvReg[0] != LV_LOW)
    else $error("low level used at half bias");
endmodule

// >>> tb/lsd_panel.sv
// passive panel model: latches every pixel that saw full drive
// assumes pin levels settle once per clk, clr held high to forget
`timescale 1ns/1ps
module lsd_panel
  import lsd_pkg::*;
(
  // clock and clear
  input  wire logic                  clk,
  input  wire logic                  clr,
  // pins
  input  lsd_level_t                 commonLevel [NUM_COM],
  input  lsd_level_t                 segLevel [NUM_SEG],
  // pixel s*4+c seen on
  output logic [NUM_SEG*NUM_COM-1:0] lit
);
  // full swing either polarity turns a pixel on; bias levels never do
  always_ff @(posedge clk) begin
    for (int s = 0; s < NUM_SEG; s++) begin
      for (int c = 0; c < NUM_COM; c++) begin
        if (clr)
          lit[s*NUM_COM+c] <= 1'h0;
        else if ((commonLevel[c] == LV_HIGH && segLevel[s] == LV_GND) ||
                 (commonLevel[c] == LV_GND && segLevel[s] == LV_HIGH))
          lit[s*NUM_COM+c] <= 1'h1;
      end
    end
  end
endmodule

// >>> tb/lcd_segment_drive_control_bench.sv
// self-checking bench for lsd_drive with a passive panel model
// assumes 125 MHz clk, inputs driven on the falling edge
`timescale 1ns/1ps
module lcd_segment_drive_control_bench;
  import lsd_pkg::*;
  logic clk, reset_n, modeWr, segEnWr, ramWr, srcTickA, srcTickB;
  logic [7:0] modeData, segEnData, ramAddr, ramData, modeOut, segEnOut, md;
  logic multiplierOn, highTiedToSupply, lcdClk, clr, tickOn, useB;
  bit tickPh;
  logic [1:0] activeCommon;
  lsd_level_t commonLevel [NUM_COM];
  lsd_level_t segLevel [NUM_SEG];
  logic [NUM_SEG-1:0] segPullUp;
  logic [159:0] lit;
  logic [7:0] ram [RAM_BYTES];
  int mismatches, checks_done, pulses, nAct, stepBad, ex, seed, sawLow;

  lsd_drive i_lsd_drive (.clk(clk), .reset_n(reset_n), .modeWr(modeWr),
    .modeData(modeData), .segEnWr(segEnWr), .segEnData(segEnData),
    .ramWr(ramWr), .ramAddr(ramAddr), .ramData(ramData),
    .srcTickA(srcTickA), .srcTickB(srcTickB), .modeOut(modeOut),
    .segEnOut(segEnOut), .multiplierOn(multiplierOn),
    .highTiedToSupply(highTiedToSupply), .lcd_drive_clock(lcdClk),
    .activeCommon(activeCommon), .commonLevel(commonLevel),
    .segLevel(segLevel), .segPullUp(segPullUp));
  lsd_panel i_lsd_panel (.clk(clk), .clr(clr), .commonLevel(commonLevel),
    .segLevel(segLevel), .lit(lit));

  // ****************************************************************
  // clock, ticks, monitors
  // ****************************************************************
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  always @(negedge clk) begin
    tickPh <= ~tickPh;
    srcTickA <= tickOn & ~useB & tickPh;
    srcTickB <= tickOn & useB & tickPh;
  end
  // counts restart while the panel is cleared
  always @(posedge clk) begin
    if (clr) begin
      pulses = 0;
      sawLow = 0;
    end else begin
      if (lcdClk)
        pulses++;
      for (int c = 0; c < NUM_COM; c++)
        if (commonLevel[c] == LV_LOW)
          sawLow = 1;
    end
    if (tickOn && nAct > 0 && activeCommon >= nAct)
      stepBad = 1;
  end

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic chk(input string n, input logic [159:0] e, input logic [159:0] g);
    checks_done++;
    if (e !== g) begin
      mismatches++;
      $display("[ERR] %s exp %0h got %0h", n, e, g);
    end
  endtask
  // kind 0 mode, 1 segment enable, 2 ram
  task automatic wr(input int k, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    {modeWr, segEnWr, ramWr} = {k == 0, k == 1, k == 2};
    {ramAddr, modeData, segEnData, ramData} = {a, d, d, d};
    @(negedge clk);
    {modeWr, segEnWr, ramWr} = 3'h0;
  endtask
  task automatic run(input int n);
    clr = 1'h1;
    tickOn <= 1'h1;
    repeat (4) @(negedge clk);
    clr = 1'h0;
    repeat (n) @(negedge clk);
    tickOn <= 1'h0;
  endtask
  function automatic logic [159:0] expLit(input int n);
    logic [159:0] r;
    for (int s = 0; s < NUM_SEG; s++)
      for (int c = 0; c < NUM_COM; c++)
        r[s*4+c] = (c < n) ? ram[s/2][(s%2)*4+c] : 1'h0;
    return r;
  endfunction
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ****************************************************************
  // sequence
  // ****************************************************************
  initial begin
    {reset_n, modeWr, segEnWr, ramWr, tickOn, useB} = 6'h0;
    {modeData, segEnData, ramAddr, ramData} = 32'h0;
    clr = 1'h0;
    nAct = 0;
    mismatches = 0;
    checks_done = 0;
    seed = $urandom(3577);
    repeat (8) @(negedge clk);
    reset_n = 1'h1;
    @(negedge clk);
    for (int c = 0; c < NUM_COM; c++) chk("comRst", LV_HIGH, commonLevel[c]);
    for (int s = 0; s < NUM_SEG; s++)
      chk("segRst", s < SEG_OUT_LO ? LV_HIGH : LV_OPEN, segLevel[s]);
    chk("pullRst", {6'h3F, 34'h0}, segPullUp);
    chk("tieRst", 1'h1, highTiedToSupply);
    for (int i = 0; i < RAM_BYTES; i++) begin
      ram[i] = 8'($urandom);
      wr(2, RAM_BASE + 8'(i), ram[i]);
    end
    wr(2, RAM_LAST + 8'h1, 8'hFF);
    wr(2, RAM_BASE - 8'h1, 8'hFF);
    wr(1, 8'h0, 8'h7F);
    chk("tie", 1'h0, highTiedToSupply);
    // every duty code under both biases, fastest divider
    for (int m = 0; m < 8; m++) begin
      md = 8'h10 | 8'(m);
      nAct = (m % 4 == 0) ? 0 : m % 4 + 1;
      wr(0, 8'h0, md);
      chk("mode", md, modeOut);
      chk("mult", 1'h1, multiplierOn);
      run(48);
      chk("lit", expLit(nAct), lit);
      chk("bias", m >= 4 && nAct > 0, sawLow);
      for (int c = nAct; c < NUM_COM; c++)
        chk("comIdle", nAct ? LV_OPEN : LV_HIGH, commonLevel[c]);
    end
    chk("step", 0, stepBad);
    // each divider ratio on each count source, duty 4
    for (int k = 0; k < 8; k++) begin
      md = {k[2], k[1:0], 5'h13};
      useB = k[2];
      wr(0, 8'h0, md);
      run(128);
      ex = 64 >> k[1:0];
      chk("ticks", 1'h1, pulses >= ex - 1 && pulses <= ex + 1);
    end
    // outputs off: multiplier gated, high level tied, pins back to idle
    wr(1, 8'h0, 8'h3F);
    chk("multOff", 1'h0, multiplierOn);
    chk("tieOff", 1'h1, highTiedToSupply);
    chk("segEn", 8'h3F, segEnOut);
    repeat (3) @(negedge clk);
    chk("segIdle", {LV_HIGH, LV_OPEN}, {segLevel[0], segLevel[SEG_OUT_LO]});
    chk("pullIdle", {6'h3F, 34'h0}, segPullUp);
    // second reset while the scan is active
    wr(1, 8'h0, 8'h7F);
    run(16);
    reset_n = 1'h0;
    repeat (2) @(negedge clk);
    reset_n = 1'h1;
    @(negedge clk);
    chk("modeRst", MODE_RST, modeOut);
    chk("tieRst2", 1'h1, highTiedToSupply);
    chk("pullRst2", {6'h3F, 34'h0}, segPullUp);
    for (int c = 0; c < NUM_COM; c++) chk("comRst2", LV_HIGH, commonLevel[c]);
    wrap_up();
  end

  initial begin
    #100000;
    mismatches++;
    wrap_up();
  end
endmodule
